// ===== shared/cksum_params.svh
// register offsets, field positions and reset values of the checksum unit
`ifndef CKSUM_PARAMS_SVH
`define CKSUM_PARAMS_SVH
`define CKSUM_ADDR_W 8
`define CKSUM_OFF_CTRL 8'hCE
`define CKSUM_OFF_INPUT 8'hDD
`define CKSUM_OFF_WINDOW 8'hDE
`define CKSUM_OFF_BITREV 8'hCF
`define CKSUM_BIT_SEL 4
`define CKSUM_BIT_INIT 3
`define CKSUM_BIT_VAL 2
`define CKSUM_PNT_HI 1
`define CKSUM_PNT_LO 0
`define CKSUM_POLY16 16'h1021
`define CKSUM_POLY32R 32'hEDB88320
`define CKSUM_RESULT_RST 32'h00000000
`define CKSUM_CTRL_RST 8'h00
`endif

// ===== shared/cksum_pkg.sv
// types shared by the checksum unit files
package cksum_pkg;
  typedef logic [31:0] cksum_result_t;
  typedef logic [1:0] cksum_pnt_t;
  // register targets, gray coded along the usual access order
  typedef enum logic [2:0] {
    CKSUM_SEL_NONE = 3'h0,
    CKSUM_SEL_CTRL = 3'h1,
    CKSUM_SEL_INPUT = 3'h3,
    CKSUM_SEL_WINDOW = 3'h2,
    CKSUM_SEL_BITREV = 3'h6
  } cksum_sel_e;
endpackage : cksum_pkg

// ===== hw/cksum_byte_step.sv
// combinational eight-step byte update for both polynomials
`timescale 1ns/1ps
`include "cksum_params.svh"
module cksum_byte_step (
  input wire logic [31:0] i_result,
  input wire logic [7:0] i_byte,
  input wire logic i_mode16,
  output logic [31:0] o_result
);
  // ****************************************************************
  // unrolled shift-and-xor loop; one cycle, so no access can race it
  // ****************************************************************
  always_comb begin
    logic [15:0] acc16;
    logic [31:0] acc32;
    logic lsb;
    lsb = 1'b0;
    acc16 = i_result[15:0] ^ {i_byte, 8'h00};
    acc32 = i_result ^ {24'h000000, i_byte};
    for (int k = 0; k < 8; k++) begin
      if (acc16[15]) begin
        acc16 = {acc16[14:0], 1'b0} ^ `CKSUM_POLY16;
      end else begin
        acc16 = {acc16[14:0], 1'b0};
      end
      lsb = acc32[0];
      acc32 = {1'b0, acc32[31:1]};
      if (lsb) begin
        acc32 = acc32 ^ `CKSUM_POLY32R;
      end
    end
    // upper half untouched while in 16-bit mode
    if (i_mode16) begin
      o_result = {i_result[31:16], acc16};
    end else begin
      o_result = acc32;
    end
  end
endmodule : cksum_byte_step

// ===== hw/cksum_unit.sv
// checksum unit: byte-stream crc16/crc32 engine with register port
`timescale 1ns/1ps
`include "cksum_params.svh"
// Behaviour
// - each byte written to the input register is folded into the result
// - running result is 16 or 32 bits depending on polynomial
// - result read through pointer and byte window, and mirrored a cycle late on O_RESULT
// - bit-reverse register reorders a written byte's bits
// - 16-bit mode is msb-first with polynomial 0x1021
// - 16-bit update xors input byte into result upper byte
// - 16-bit first byte uses chosen preset zeros or ones
// - 16-bit: eight steps, shift left, xor 0x1021 if top bit set
// - 32-bit mode uses reflected 0x04C11DB7
// - 32-bit update xors input byte into result low byte
// - 32-bit: eight steps, shift right, xor 0xEDB88320 if low bit was one
// - 32-bit first byte uses chosen preset zeros or ones
// - select bit zero means 32-bit, one means 16-bit
// - init strobe loads all zeros or all ones per preset bit
// - 2-bit pointer picks window byte, advances per access, aliases in 16-bit
// - result holds until init, window write or new input byte
module cksum_unit (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [`CKSUM_ADDR_W-1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_MODE16,
  output logic [31:0] O_RESULT
);
  // ****************************************************************
  // decode and control state
  // ****************************************************************
  cksum_pkg::cksum_sel_e sel;
  logic mode16;
  logic preset_ones;
  cksum_pkg::cksum_pnt_t pnt;
  cksum_pkg::cksum_result_t result;
  cksum_pkg::cksum_result_t next_result;
  logic [7:0] bitrev;
  logic [7:0] bitrev_flip;
  logic [1:0] eff_pnt;
  logic [7:0] win_byte;
  logic [7:0] ctrl_read;

  // address decode as an if chain
  // unmapped offsets fall to none, so stray writes change nothing
  // and stray reads return zero
  always_comb begin
    if (I_ADDR == `CKSUM_OFF_CTRL) begin
      sel = cksum_pkg::CKSUM_SEL_CTRL;
    end else if (I_ADDR == `CKSUM_OFF_INPUT) begin
      sel = cksum_pkg::CKSUM_SEL_INPUT;
    end else if (I_ADDR == `CKSUM_OFF_WINDOW) begin
      sel = cksum_pkg::CKSUM_SEL_WINDOW;
    end else if (I_ADDR == `CKSUM_OFF_BITREV) begin
      sel = cksum_pkg::CKSUM_SEL_BITREV;
    end else begin
      sel = cksum_pkg::CKSUM_SEL_NONE;
    end
  end

  // 16-bit mode folds pointer onto the low two bytes
  // the stored pointer keeps counting mod 4; only the byte it picks
  // is folded, so a read-back of control still shows the raw count
  assign eff_pnt = mode16 ? {1'b0, pnt[0]} : pnt;
  assign win_byte = result[eff_pnt*8 +: 8];
  assign ctrl_read = {3'h0, mode16, 1'b0, preset_ones, pnt};

  // ****************************************************************
  // byte update datapath
  // ****************************************************************
  // whole byte folded in one cycle: costs a deep xor tree but lets
  // software read the window right after the input write
  cksum_byte_step u_step (
    .i_result(result),
    .i_byte(I_WDATA),
    .i_mode16(mode16),
    .o_result(next_result)
  );

  // polynomial and preset select; init reads back as zero
  // changing the select does not touch the result; software must
  // init again after switching polynomials
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      mode16 <= 1'b0;
      preset_ones <= 1'b0;
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL) begin
      mode16 <= I_WDATA[`CKSUM_BIT_SEL];
      preset_ones <= I_WDATA[`CKSUM_BIT_VAL];
    end
  end

  // pointer: written through control, advanced by each window access
  // a control write always reloads it, so software sets the start
  // byte in the same write that picks polynomial and preset
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pnt <= 2'h0;
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL) begin
      pnt <= I_WDATA[`CKSUM_PNT_HI:`CKSUM_PNT_LO];
    end else if ((I_WR || I_RD) && sel == cksum_pkg::CKSUM_SEL_WINDOW) begin
      pnt <= pnt + 2'h1;
    end
  end

  // result register; holds unless one of three causes acts
  // the three causes come from distinct addresses, so they can never
  // collide within one cycle; the order below is only for clarity
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      result <= `CKSUM_RESULT_RST;
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL &&
                 I_WDATA[`CKSUM_BIT_INIT]) begin
      // preset uses the value bit written in the same cycle
      result <= {32{I_WDATA[`CKSUM_BIT_VAL]}};
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_INPUT) begin
      result <= next_result;
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_WINDOW) begin
      result[eff_pnt*8 +: 8] <= I_WDATA;
    end // otherwise hold
  end

  // bit reverse helper: stores the written byte mirrored
  // pure wiring, no logic depth; the flop only holds the answer
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      bitrev_flip[b] = I_WDATA[7-b];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      bitrev <= 8'h00;
    end else if (I_WR && sel == cksum_pkg::CKSUM_SEL_BITREV) begin
      bitrev <= bitrev_flip;
    end
  end

  // ****************************************************************
  // read data, valid only in the cycle after the read strobe
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      if (sel == cksum_pkg::CKSUM_SEL_CTRL) begin
        O_RDATA <= ctrl_read;
      end else if (sel == cksum_pkg::CKSUM_SEL_WINDOW) begin
        O_RDATA <= win_byte;
      end else if (sel == cksum_pkg::CKSUM_SEL_BITREV) begin
        O_RDATA <= bitrev;
      end else begin
        O_RDATA <= 8'h00; // input register and unmapped read zero
      end
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // status mirrors registered to keep outputs flop-driven
  // one cycle late; meant for observation, not for the read path,
  // which uses the live result through the window
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_MODE16 <= 1'b0;
      O_RESULT <= `CKSUM_RESULT_RST;
    end else begin
      O_MODE16 <= mode16;
      O_RESULT <= result;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_init_preset: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && I_ADDR == `CKSUM_OFF_CTRL && I_WDATA[3])
    |=> result == {32{$past(I_WDATA[2])}})
    else $error("init did not load preset");
  a_input_fold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && I_ADDR == `CKSUM_OFF_INPUT) |=> result == $past(next_result))
    else $error("input byte not folded");
  a_result_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_WR |=> $stable(result))
    else $error("result changed without cause");
  a_upper_keep: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode16 && I_WR && I_ADDR == `CKSUM_OFF_INPUT)
    |=> result[31:16] == $past(result[31:16]))
    else $error("upper half changed in 16-bit mode");
  a_pnt_advance: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    ((I_WR || I_RD) && I_ADDR == `CKSUM_OFF_WINDOW)
    |=> pnt == $past(pnt) + 2'h1)
    else $error("pointer did not advance");
  a_window_read: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_RD && I_ADDR == `CKSUM_OFF_WINDOW) |=> O_RDATA == $past(win_byte))
    else $error("window read wrong byte");
  a_alias16: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode16 && I_RD && I_ADDR == `CKSUM_OFF_WINDOW)
    |=> O_RDATA == ($past(pnt[0]) ? $past(result[15:8])
                                  : $past(result[7:0])))
    else $error("16-bit pointer not aliased");
  a_bitrev_mirror: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && I_ADDR == `CKSUM_OFF_BITREV)
    |=> bitrev == {<<{$past(I_WDATA)}})
    else $error("bit reverse wrong");
  a_mode_select: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && I_ADDR == `CKSUM_OFF_CTRL) |=> mode16 == $past(I_WDATA[4]))
    else $error("polynomial select not stored");
  a_read_idle: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_RD |=> O_RDATA == 8'h00)
    else $error("read data outside read cycle");

  // window writes land on the byte the pointer picks
  a_win_write32: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (!mode16 && I_WR && sel == cksum_pkg::CKSUM_SEL_WINDOW)
    |=> result[$past(pnt)*8 +: 8] == $past(I_WDATA))
    else $error("window write missed its byte");
  a_win_write16: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode16 && I_WR && sel == cksum_pkg::CKSUM_SEL_WINDOW)
    |=> ($past(pnt[0]) ? result[15:8] : result[7:0]) == $past(I_WDATA))
    else $error("16-bit window write not aliased");

  // read-back of the other registers
  a_ctrl_read: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_RD && sel == cksum_pkg::CKSUM_SEL_CTRL)
    |=> O_RDATA == {3'h0, $past(mode16), 1'b0, $past(preset_ones),
                    $past(pnt)})
    else $error("control read wrong");
  a_bitrev_read: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_RD && sel == cksum_pkg::CKSUM_SEL_BITREV)
    |=> O_RDATA == $past(bitrev))
    else $error("bit reverse read wrong");
  a_input_read: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_RD && sel == cksum_pkg::CKSUM_SEL_INPUT)
    |=> O_RDATA == 8'h00)
    else $error("input register read not zero");

  // control fields load and hold
  a_pnt_load: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL)
    |=> pnt == $past(I_WDATA[1:0]))
    else $error("pointer not loaded");
  a_preset_store: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL)
    |=> preset_ones == $past(I_WDATA[2]))
    else $error("preset select not stored");
  a_mode_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !(I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL)
    |=> $stable(mode16))
    else $error("polynomial select changed");
  a_preset_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !(I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL)
    |=> $stable(preset_ones))
    else $error("preset select changed");
  a_pnt_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (!(I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL) &&
     !((I_WR || I_RD) && sel == cksum_pkg::CKSUM_SEL_WINDOW))
    |=> $stable(pnt))
    else $error("pointer moved without access");
  a_bitrev_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !(I_WR && sel == cksum_pkg::CKSUM_SEL_BITREV)
    |=> $stable(bitrev))
    else $error("bit reverse changed");

  // stray writes, init width, reset and mirrors
  a_unmapped_wr: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (I_WR && sel == cksum_pkg::CKSUM_SEL_NONE)
    |=> $stable(result) && $stable(pnt) && $stable(mode16) &&
        $stable(bitrev))
    else $error("unmapped write changed state");
  a_init_upper: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (mode16 && I_WR && sel == cksum_pkg::CKSUM_SEL_CTRL && I_WDATA[3])
    |=> result[31:16] == {16{$past(I_WDATA[2])}})
    else $error("init skipped upper half");
  a_reset_state: assert property (@(posedge I_CLK)
    !I_RESETN |=> result == `CKSUM_RESULT_RST && pnt == 2'h0 && !mode16)
    else $error("reset state wrong");
  a_mirror_out: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    1'b1 |=> O_RESULT == $past(result) && O_MODE16 == $past(mode16))
    else $error("status mirror wrong");

  // ****************************************************************
  // cover points
  // ****************************************************************

  c_fold16: cover property (@(posedge I_CLK)
    mode16 && I_WR && I_ADDR == `CKSUM_OFF_INPUT);
  c_fold32: cover property (@(posedge I_CLK)
    !mode16 && I_WR && I_ADDR == `CKSUM_OFF_INPUT);
  c_init_ones: cover property (@(posedge I_CLK)
    I_WR && I_ADDR == `CKSUM_OFF_CTRL && I_WDATA[3] && I_WDATA[2]);
  c_window_wrap: cover property (@(posedge I_CLK)
    I_RD && I_ADDR == `CKSUM_OFF_WINDOW && pnt == 2'h3);
  // window write while the pointer sits at a start byte
  c_win_write: cover property (@(posedge I_CLK)
    I_WR && I_ADDR == `CKSUM_OFF_WINDOW && pnt == 2'h2);
endmodule : cksum_unit

// ===== dv/cksum_core_model.sv
// processor core model: plain register-port master for the checksum unit
`timescale 1ns/1ps
module cksum_core_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // each task sets both strobes once, so accesses may run back to back
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask : rd_reg
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : idle
endmodule : cksum_core_model

// ===== dv/tb_cksum_unit.sv
// self-checking bench for the checksum unit
`timescale 1ns/1ps
`include "cksum_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_cksum_unit;
  // ****************************************
  // clock, reset, bus and checking state
  // ****************************************
  logic I_CLK;
  logic I_RESETN;
  logic [7:0] addr, wdata, rdata, e;
  logic wr, rd, mode16, rd_d;
  logic [31:0] result;
  logic [7:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  cksum_unit dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_MODE16(mode16), .O_RESULT(result));
  cksum_core_model core (.clk(I_CLK), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  // read data stand only in the cycle after the strobe
  always @(posedge I_CLK) rd_d <= rd;
  always @(negedge I_CLK) if (rd_d === 1'b1) begin
    e = exp_q.pop_front();
    `CHK(rdata, e)
  end
  // reference byte update; upper half untouched in 16-bit mode
  function automatic logic [31:0] step(logic [31:0] c, logic [7:0] b,
                                       logic m16);
    if (m16) c[15:8] = c[15:8] ^ b;
    else c[7:0] = c[7:0] ^ b;
    for (int i = 0; i < 8; i++) begin
      if (m16) c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
      else c = (c >> 1) ^ (c[0] ? 32'hEDB88320 : 32'h00000000);
    end
    return c;
  endfunction : step
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    core.rd_reg(a);
  endtask : rd_chk
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // init, stream bytes, then read the window four times back to back, bytes 0 and 1 twice over in 16-bit mode
  task automatic run(input logic m16, input logic pv, input logic [7:0] q[$],
                     input bit tab, input logic [31:0] t);
    logic [31:0] r;
    logic [31:0] x;
    r = pv ? 32'hFFFFFFFF : 32'h00000000;
    core.wr_reg(`CKSUM_OFF_CTRL, {3'h0, m16, 1'b1, pv, 2'h0});
    foreach (q[i]) begin
      r = step(r, q[i], m16);
      core.wr_reg(`CKSUM_OFF_INPUT, q[i]);
    end
    x = tab ? t : r;
    for (int k = 0; k < 4; k++)
      rd_chk(`CKSUM_OFF_WINDOW, x[8*(m16 ? k % 2 : k) +: 8]);
    rd_chk(`CKSUM_OFF_CTRL, {3'h0, m16, 1'b0, pv, 2'h0});
    core.idle();
    core.idle();
    `CHK(mode16, m16)
    `CHK(result, r)
  endtask : run
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] q[$];
    logic [7:0] d0, d1;
    I_RESETN = 1'b0;
    void'($urandom(32'h4fe2));
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    rd_chk(`CKSUM_OFF_CTRL, 8'h00);
    rd_chk(`CKSUM_OFF_WINDOW, 8'h00);
    done("reset");
    run(1'b1, 1'b1, '{8'h63}, 1, 32'h0000BD35);
    run(1'b1, 1'b1, '{8'hAA, 8'hBB, 8'hCC}, 1, 32'h00006CF6);
    run(1'b0, 1'b1, '{8'h63}, 1, 32'hF9462090);
    run(1'b0, 1'b1, '{8'hAA, 8'hBB, 8'hCC}, 1, 32'h41B207B3);
    done("table");
    for (int m = 0; m < 4; m++) begin
      q = {};
      repeat (6) q.push_back(8'($urandom()));
      run(m[1], m[0], q, 0, 32'h00000000);
    end
    done("random");
    // window write starts at the loaded pointer and steps upward
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    core.wr_reg(`CKSUM_OFF_CTRL, 8'h0A);
    core.wr_reg(`CKSUM_OFF_WINDOW, d0);
    core.wr_reg(`CKSUM_OFF_WINDOW, d1);
    core.wr_reg(`CKSUM_OFF_CTRL, 8'h00);
    for (int k = 0; k < 4; k++)
      rd_chk(`CKSUM_OFF_WINDOW, k < 2 ? 8'h00 : (k == 2 ? d0 : d1));
    done("window");
    core.wr_reg(`CKSUM_OFF_BITREV, d0);
    rd_chk(`CKSUM_OFF_BITREV, {<<{d0}});
    core.wr_reg(8'h00, d1);
    rd_chk(8'h00, 8'h00);
    rd_chk(`CKSUM_OFF_INPUT, 8'h00);
    core.idle();
    core.idle();
    done("misc");
    summarize();
  end
  // watchdog well beyond the roughly 120 cycles the tests take
  initial begin
    repeat (3000) @(posedge I_CLK);
    fails++;
    summarize();
  end
endmodule : tb_cksum_unit
